// ### hw/eepc_pkg.sv
// Constants and carrier types shared by the EEPROM program control block.
// Assumes an AXI4-Lite master with a 16-bit byte address and 32-bit data.
package eepc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] EEPC_CTRL_IDX  = 16'h103B;  // Program control.
  localparam logic [15:0] EEPC_OPT_IDX   = 16'h1040;  // Pump clock select.
  localparam logic [15:0] EEPC_STAT_IDX  = 16'h1041;  // Block status.
  localparam logic [15:0] EEPC_CTRL_ADDR = {EEPC_CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] EEPC_OPT_ADDR  = {EEPC_OPT_IDX[13:0], 2'b00};
  localparam logic [15:0] EEPC_STAT_ADDR = {EEPC_STAT_IDX[13:0], 2'b00};

  // Memory geometry: one byte per bus word from byte address zero.
  localparam int          EEPC_MEM_BYTES = 512;
  localparam int          EEPC_MEM_AW    = 9;
  localparam int          EEPC_ROW_BYTES = 16;
  localparam int          EEPC_ROW_AW    = 4;
  localparam int          EEPC_ROWS      = 32;
  localparam logic [7:0]  EEPC_ERASED    = 8'hFF;

  // Program control field positions and reset value.
  localparam int          EEPC_PGM_BIT   = 0;
  localparam int          EEPC_LAT_BIT   = 1;
  localparam int          EEPC_ERASE_BIT = 2;
  localparam int          EEPC_ROW_BIT   = 3;
  localparam int          EEPC_BYTE_BIT  = 4;
  localparam int          EEPC_NONE_BIT  = 5;
  localparam int          EEPC_EVEN_BIT  = 6;
  localparam int          EEPC_ODD_BIT   = 7;
  localparam logic [7:0]  EEPC_CTRL_RST  = 8'h00;

  // Own register fields.
  localparam int          EEPC_SRC_BIT   = 0;
  localparam int          EEPC_HV_BIT    = 0;
  localparam int          EEPC_LATV_BIT  = 1;

  // Bus responses.
  localparam logic [1:0]  EEPC_OKAY      = 2'h0;
  localparam logic [1:0]  EEPC_DECERR    = 2'h3;

  // Address regions.
  typedef enum {EEPC_SEL_MEM, EEPC_SEL_CTRL, EEPC_SEL_OPT, EEPC_SEL_STAT,
                EEPC_SEL_NONE} eepc_sel_e;

  // Signals from the bus master.
  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } eepc_axi_req_s;

  // Signals back to the bus master.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eepc_axi_rsp_s;

endpackage

// ### hw/eepc_top.sv
// EEPROM program control block with its 512-byte array and AXI4-Lite slave.
// Assumes one clock, ref_clk, and a master that keeps AXI4-Lite handshakes.
`timescale 1ns/1ns
module eepc_top (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire eepc_pkg::eepc_axi_req_s axi_req,
  output eepc_pkg::eepc_axi_rsp_s     axi_rsp,
  output logic                        hv_pump_on,
  output logic                        pump_clk_sel,
  output logic                        adc_clk_sel
);
  import eepc_pkg::*;

  // Maps a byte address to its region; used by both read and write paths.
  function automatic eepc_sel_e eepc_decode(input logic [15:0] addr);
    if (addr[15:11] == 5'h00 && addr[1:0] == 2'h0) begin
      return EEPC_SEL_MEM;
    end else if (addr == EEPC_CTRL_ADDR) begin
      return EEPC_SEL_CTRL;
    end else if (addr == EEPC_OPT_ADDR) begin
      return EEPC_SEL_OPT;
    end else if (addr == EEPC_STAT_ADDR) begin
      return EEPC_SEL_STAT;
    end else begin
      return EEPC_SEL_NONE;
    end
  endfunction

  // Bus channel state.
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic        aw_full_reg, w_full_reg;
  logic [15:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        w_lane0_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        aw_full_next, w_full_next, bvalid_next, rvalid_next;

  // Block state.
  logic [7:0]  ctrl_reg;               // Program control register.
  logic        src_reg;                // Pump clock select register bit.
  logic        hv_reg, pclk_reg, aclk_reg;
  logic [8:0]  lat_addr_reg;           // Latched memory address.
  logic [7:0]  lat_data_reg;           // Latched programming data.
  logic        lat_valid_reg;          // A latch write is pending.
  logic [7:0]  mem [EEPC_MEM_BYTES];   // The array itself.

  // Decoded events.
  logic        aw_take, w_take, ar_take, wr_fire, commit;
  eepc_sel_e   wsel, rsel;
  logic [7:0]  ctrl_wr_val;

  assign aw_take = axi_req.awvalid & awready_reg;
  assign w_take  = axi_req.wvalid & wready_reg;
  assign ar_take = axi_req.arvalid & arready_reg;
  // A write executes once address and data are both held and no answer waits.
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wsel    = eepc_decode(aw_addr_reg);
  assign rsel    = eepc_decode(axi_req.araddr);

  // Written value: bit five dropped, pump bit kept only with latch bit set.
  always_comb begin
    ctrl_wr_val                 = w_data_reg[7:0];
    ctrl_wr_val[EEPC_NONE_BIT]  = 1'b0;
    ctrl_wr_val[EEPC_PGM_BIT]   = w_data_reg[EEPC_PGM_BIT] &
                                  w_data_reg[EEPC_LAT_BIT];
  end

  // The pulse ends when software clears the pump bit; the array updates then.
  assign commit = wr_fire & (wsel == EEPC_SEL_CTRL) & w_lane0_reg &
                  ctrl_reg[EEPC_PGM_BIT] & ~w_data_reg[EEPC_PGM_BIT];

  // Next state of the write and read channels.
  always_comb begin
    aw_full_next = (aw_full_reg & ~wr_fire) | aw_take;
    w_full_next  = (w_full_reg & ~wr_fire) | w_take;
    bvalid_next  = (bvalid_reg & ~axi_req.bready) | wr_fire;
    rvalid_next  = (rvalid_reg & ~axi_req.rready) | ar_take;
  end

  // Write channel: address and data are held in either order.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= EEPC_OKAY;
      aw_addr_reg <= 16'h0000;
      w_data_reg  <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      // Ready drops while a word is held or an answer is pending.
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (aw_take) begin
        aw_addr_reg <= axi_req.awaddr;
      end
      if (w_take) begin
        w_data_reg  <= axi_req.wdata;
        w_lane0_reg <= axi_req.wstrb[0];
      end
      // Unmapped addresses answer a decode error and change nothing.
      if (wr_fire) begin
        bresp_reg <= (wsel == EEPC_SEL_NONE) ? EEPC_DECERR : EEPC_OKAY;
      end
    end
  end

  // Read channel: the answer is registered at the edge that takes the address.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= EEPC_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= EEPC_OKAY;
        unique case (rsel)
          // Array reads are blocked while writes go to the latches.
          EEPC_SEL_MEM: begin
            if (!ctrl_reg[EEPC_LAT_BIT]) begin
              rdata_reg[7:0] <= mem[axi_req.araddr[10:2]];
            end
          end
          EEPC_SEL_CTRL: rdata_reg[7:0] <= ctrl_reg;
          EEPC_SEL_OPT:  rdata_reg[EEPC_SRC_BIT] <= src_reg;
          EEPC_SEL_STAT: begin
            rdata_reg[EEPC_HV_BIT]   <= hv_reg;
            rdata_reg[EEPC_LATV_BIT] <= lat_valid_reg;
          end
          EEPC_SEL_NONE: rresp_reg <= EEPC_DECERR;
        endcase
      end
    end
  end

  // Program control register; reset leaves the array in normal reads.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= EEPC_CTRL_RST;
    end else if (wr_fire && wsel == EEPC_SEL_CTRL && w_lane0_reg) begin
      ctrl_reg <= ctrl_wr_val;
    end
  end

  // Pump clock select; the pump and the converter follow the same bit.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_reg <= 1'b0;
    end else if (wr_fire && wsel == EEPC_SEL_OPT && w_lane0_reg) begin
      src_reg <= w_data_reg[EEPC_SRC_BIT];
    end
  end

  // Outputs to the analog side; software allows settling time itself.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hv_reg   <= 1'b0;
      pclk_reg <= 1'b0;
      aclk_reg <= 1'b0;
    end else begin
      hv_reg   <= ctrl_reg[EEPC_PGM_BIT] & ctrl_reg[EEPC_LAT_BIT];
      pclk_reg <= src_reg;
      aclk_reg <= src_reg;
    end
  end

  // Address and data latches catch array writes while the latch bit is set.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_addr_reg  <= 9'h000;
      lat_data_reg  <= 8'h00;
      lat_valid_reg <= 1'b0;
    end else if (wr_fire && wsel == EEPC_SEL_MEM && w_lane0_reg &&
                 ctrl_reg[EEPC_LAT_BIT]) begin
      lat_addr_reg  <= aw_addr_reg[10:2];
      lat_data_reg  <= w_data_reg[7:0];
      lat_valid_reg <= 1'b1;
    end else if (commit) begin
      lat_valid_reg <= 1'b0;
    end
  end

  // The array comes up erased, so a cold model reads all ones.
  // Programming can only clear bits; raising one needs an erase first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < EEPC_MEM_BYTES; i++) begin
        mem[i] <= EEPC_ERASED;
      end
    end else if (commit) begin
      if (ctrl_reg[EEPC_ERASE_BIT]) begin
        if (ctrl_reg[EEPC_BYTE_BIT]) begin
          mem[lat_addr_reg] <= EEPC_ERASED;
        end else if (ctrl_reg[EEPC_ROW_BIT]) begin
          for (int i = 0; i < EEPC_ROW_BYTES; i++) begin
            mem[{lat_addr_reg[8:4], 4'(i)}] <= EEPC_ERASED;
          end
        end else begin
          for (int i = 0; i < EEPC_MEM_BYTES; i++) begin
            mem[i] <= EEPC_ERASED;
          end
        end
      end else if (ctrl_reg[EEPC_ODD_BIT] || ctrl_reg[EEPC_EVEN_BIT]) begin
        // Test mode: the latched column is programmed in every chosen row.
        for (int r = 0; r < EEPC_ROWS; r++) begin
          if ((r % 2 == 1 && ctrl_reg[EEPC_ODD_BIT]) ||
              (r % 2 == 0 && ctrl_reg[EEPC_EVEN_BIT])) begin
            mem[{5'(r), lat_addr_reg[3:0]}] <=
              mem[{5'(r), lat_addr_reg[3:0]}] & lat_data_reg;
          end
        end
      end else begin
        mem[lat_addr_reg] <= mem[lat_addr_reg] & lat_data_reg;
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign axi_rsp.awready = awready_reg;
  assign axi_rsp.wready  = wready_reg;
  assign axi_rsp.bvalid  = bvalid_reg;
  assign axi_rsp.bresp   = bresp_reg;
  assign axi_rsp.arready = arready_reg;
  assign axi_rsp.rvalid  = rvalid_reg;
  assign axi_rsp.rdata   = rdata_reg;
  assign axi_rsp.rresp   = rresp_reg;
  assign hv_pump_on      = hv_reg;
  assign pump_clk_sel    = pclk_reg;
  assign adc_clk_sel     = aclk_reg;

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic first_reg;  // High in the first cycle after reset release.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  property p_reset_ctrl;
    first_reg |-> ctrl_reg == EEPC_CTRL_RST && !hv_pump_on;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not clear");

  property p_bit5_read;
    ar_take && rsel == EEPC_SEL_CTRL |=> rvalid_reg && !rdata_reg[EEPC_NONE_BIT];
  endproperty
  a_bit5_read: assert property (p_bit5_read) else $error("bit five set");

  property p_hv_latch;
    ctrl_reg[EEPC_PGM_BIT] |-> ctrl_reg[EEPC_LAT_BIT] ##1 hv_pump_on;
  endproperty
  a_hv_latch: assert property (p_hv_latch) else $error("pump without latch");

  property p_prog_and;
    commit && !ctrl_reg[EEPC_ERASE_BIT] && !ctrl_reg[EEPC_ODD_BIT] &&
      !ctrl_reg[EEPC_EVEN_BIT]
      |=> mem[lat_addr_reg] == ($past(mem[lat_addr_reg]) & lat_data_reg);
  endproperty
  a_prog_and: assert property (p_prog_and) else $error("program not AND");

  property p_byte_erase;
    commit && ctrl_reg[EEPC_ERASE_BIT] && ctrl_reg[EEPC_BYTE_BIT]
      |=> mem[lat_addr_reg] == EEPC_ERASED;
  endproperty
  a_byte_erase: assert property (p_byte_erase) else $error("byte erase failed");

  property p_row_erase;
    commit && ctrl_reg[EEPC_ERASE_BIT] && !ctrl_reg[EEPC_BYTE_BIT] &&
      ctrl_reg[EEPC_ROW_BIT]
      |=> mem[{lat_addr_reg[8:4], 4'hF}] == EEPC_ERASED &&
          mem[{lat_addr_reg[8:4], 4'h0}] == EEPC_ERASED;
  endproperty
  a_row_erase: assert property (p_row_erase) else $error("row erase failed");

  property p_bulk_erase;
    commit && ctrl_reg[EEPC_ERASE_BIT] && !ctrl_reg[EEPC_BYTE_BIT] &&
      !ctrl_reg[EEPC_ROW_BIT]
      |=> mem[0] == EEPC_ERASED && mem[EEPC_MEM_BYTES - 1] == EEPC_ERASED;
  endproperty
  a_bulk_erase: assert property (p_bulk_erase) else $error("bulk erase failed");

  property p_prog_no_rise;
    commit && !ctrl_reg[EEPC_ERASE_BIT]
      |=> (mem[lat_addr_reg] & ~$past(mem[lat_addr_reg])) == 8'h00;
  endproperty
  a_prog_no_rise: assert property (p_prog_no_rise) else $error("bit raised");

  property p_odd_rows;
    commit && !ctrl_reg[EEPC_ERASE_BIT] && ctrl_reg[EEPC_ODD_BIT]
      |=> mem[{5'h01, lat_addr_reg[3:0]}] ==
          ($past(mem[{5'h01, lat_addr_reg[3:0]}]) & lat_data_reg);
  endproperty
  a_odd_rows: assert property (p_odd_rows) else $error("odd row missed");

  property p_clk_src;
    wr_fire && wsel == EEPC_SEL_OPT && w_lane0_reg
      |-> ##2 pump_clk_sel == $past(w_data_reg[EEPC_SRC_BIT], 2);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("pump clock not switched");

  property p_adc_sel;
    adc_clk_sel == pump_clk_sel;
  endproperty
  a_adc_sel: assert property (p_adc_sel) else $error("converter clock differs");

  c_byte_erase: cover property (commit && ctrl_reg[EEPC_ERASE_BIT] &&
                                ctrl_reg[EEPC_BYTE_BIT]);
  c_bulk_erase: cover property (commit && ctrl_reg[EEPC_ERASE_BIT] &&
                                !ctrl_reg[EEPC_BYTE_BIT] && !ctrl_reg[EEPC_ROW_BIT]);
  c_program:    cover property (commit && !ctrl_reg[EEPC_ERASE_BIT]);
  c_mem_read:   cover property (ar_take && rsel == EEPC_SEL_MEM);

endmodule

// ### verif/eepc_top_tb_top.sv
// Self-checking bench for the EEPROM program control block.
// Assumes the design reports DECERR for unmapped addresses and commits at pump fall.
`timescale 1ns/1ns
module eepc_top_tb_top;
  import eepc_pkg::*;

  logic          ref_clk;      // Bus clock, 4 ns period.
  logic          resetn;       // Active-low asynchronous reset.
  eepc_axi_req_s req;          // Master side of the register bus.
  eepc_axi_rsp_s rsp;          // Slave answers.
  logic          hv_pump_on;   // High voltage applied.
  logic          pump_clk_sel; // Pump clocked from the RC oscillator.
  logic          adc_clk_sel;  // Converter clock select.
  logic [31:0]   rd_q;         // Data of the last read.
  logic [1:0]    rs_q;         // Response of the last transfer.
  int            error_cnt;    // Mismatches seen.
  int            checks_done;  // Comparisons made.
  // Real pulses and settling take milliseconds; short stand-ins keep the run brief.
  localparam int PULSE_CYC  = 20;
  localparam int SETTLE_CYC = 20;

  eepc_top i_eepc_top (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .axi_req      (req),
    .axi_rsp      (rsp),
    .hv_pump_on   (hv_pump_on),
    .pump_clk_sel (pump_clk_sel),
    .adc_clk_sel  (adc_clk_sel)
  );

  // Free-running clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One write; each channel is released at the edge where it is taken.
  // Starting on a fresh edge keeps bready from being set twice in one step.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) begin
        req.awvalid <= 1'b0;
      end
      if (rsp.wready) begin
        req.wvalid <= 1'b0;
      end
      n++;
    end while (!rsp.bvalid && n < 400);
    if (n >= 400) begin
      chk("write answer", 32'h0, 32'h1);
    end
    rs_q = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // One read; data and response are taken at the rvalid edge.
  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready) begin
        req.arvalid <= 1'b0;
      end
      n++;
    end while (!rsp.rvalid && n < 400);
    if (n >= 400) begin
      chk("read answer", 32'h0, 32'h1);
    end
    rd_q = rsp.rdata;
    rs_q = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Reads one array byte and compares it.
  task automatic rda(input logic [8:0] i, input logic [7:0] e);
    rd({5'h0, i, 2'b00});
    chk("array byte", rd_q, {24'h0, e});
  endtask

  // Full latch, pump, release sequence; mode adds the erase, row, byte and odd/even row bits.
  task automatic pgm(input logic [8:0] i, input logic [7:0] d, input logic [7:0] m);
    wr(EEPC_CTRL_ADDR, {24'h0, m | 8'h02});
    wr({5'h0, i, 2'b00}, {24'h0, d});
    wr(EEPC_CTRL_ADDR, {24'h0, m | 8'h03});
    @(posedge ref_clk);
    #1;
    chk("hv on", {31'h0, hv_pump_on}, 32'h1);
    rd(EEPC_STAT_ADDR);
    chk("status", rd_q, 32'h3);
    repeat (PULSE_CYC) @(posedge ref_clk);
    wr(EEPC_CTRL_ADDR, {24'h0, m | 8'h02});
    wr(EEPC_CTRL_ADDR, 32'h0);
  endtask

  // Watchdog: the tests take under a thousand cycles, so 50000 is ample.
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // Main sequence.
  initial begin
    req = '0;
    resetn = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;

    rd(EEPC_CTRL_ADDR);
    chk("ctrl reset", rd_q, 32'h0);
    rda(9'd0, EEPC_ERASED);
    rda(9'd511, EEPC_ERASED);
    chk("hv reset", {31'h0, hv_pump_on}, 32'h0);
    $display("test reset done");

    // All writable bits set, pump off so nothing commits.
    wr(EEPC_CTRL_ADDR, 32'h0000_00FE);
    rd(EEPC_CTRL_ADDR);
    chk("ctrl bit five", rd_q, 32'h0000_00DE);
    rda(9'd0, 8'h00);
    wr(EEPC_CTRL_ADDR, 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    chk("hv without latch", {31'h0, hv_pump_on}, 32'h0);
    rd(EEPC_CTRL_ADDR);
    chk("pump without latch", rd_q, 32'h0);
    $display("test control done");

    // Programming only clears bits.
    pgm(9'd5, 8'h55, 8'h00);
    pgm(9'd5, 8'h50, 8'h00);
    rda(9'd5, 8'h50);
    wr(16'h0014, 32'h0000_0000);
    rda(9'd5, 8'h50);
    pgm(9'd5, 8'hAF, 8'h00);
    rda(9'd5, 8'h00);
    pgm(9'd6, 8'h0F, 8'h00);
    pgm(9'd21, 8'h3C, 8'h00);
    $display("test program done");

    // Byte erase with the row bit also set: only one byte.
    pgm(9'd5, 8'h00, 8'h1C);
    rda(9'd5, 8'hFF);
    rda(9'd6, 8'h0F);
    // Row erase of row zero leaves row one.
    pgm(9'd6, 8'h00, 8'h0C);
    rda(9'd6, 8'hFF);
    rda(9'd21, 8'h3C);
    // Bulk erase.
    pgm(9'd0, 8'h00, 8'h04);
    rda(9'd21, 8'hFF);
    $display("test erase done");

    // Odd rows: row one, column three lands in row three as well.
    pgm(9'd19, 8'hA5, 8'h80);
    rda(9'd51, 8'hA5);
    rda(9'd35, 8'hFF);
    // Even rows: row two, column two lands in row zero as well.
    pgm(9'd34, 8'h5A, 8'h40);
    rda(9'd2, 8'h5A);
    rda(9'd18, 8'hFF);
    $display("test odd even done");

    // Pump clock select drives both clock selects.
    wr(EEPC_OPT_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("pump clk sel", {31'h0, pump_clk_sel}, 32'h1);
    chk("adc clk sel", {31'h0, adc_clk_sel}, 32'h1);
    repeat (SETTLE_CYC) @(posedge ref_clk);
    pgm(9'd7, 8'h12, 8'h00);
    rda(9'd7, 8'h12);
    wr(EEPC_OPT_ADDR, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("pump clk back", {31'h0, pump_clk_sel}, 32'h0);
    chk("adc clk back", {31'h0, adc_clk_sel}, 32'h0);
    $display("test clock select done");

    // Unmapped address is refused on both paths.
    wr(16'h2000, 32'h0000_00AA);
    chk("unmapped bresp", {30'h0, rs_q}, {30'h0, EEPC_DECERR});
    rd(16'h2000);
    chk("unmapped rresp", {30'h0, rs_q}, {30'h0, EEPC_DECERR});

    // Reset in mid-run clears the control register again.
    wr(EEPC_CTRL_ADDR, 32'h0000_0016);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(EEPC_CTRL_ADDR);
    chk("ctrl second reset", rd_q, 32'h0);
    $display("test bus and reset done");
    results();
  end
endmodule
